// ---- hdl/flash_guard_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH
`define ADDR_KEY          8'hF5
`define ADDR_DATA         8'hF6
`define ADDR_PROTECT      8'hFA
`define ADDR_EVENT        8'hFB
`define ADDR_PAGE         8'hFC
`define ADDR_ROW          8'hFD
`define ADDR_COL          8'hFE
`define ADDR_PGCTL        8'hFF
`define PROTECT_RESET     8'hFF
`define EVENT_RESET       8'h00
`define PAGE_RESET        8'h00
`define KEY_FIRST         8'hB6
`define KEY_SECOND        8'h49
`define EV_COMPLETION_IRQ_ENABLE       7
`define EV_ERROR_IRQ_ENABLE        6
`define EV_DONE           5
`define EV_WRITE_VIOLATION_FLAG         3
`define EV_ROW_PROGRAM_TIMEOUT_FLAG         2
`define EV_PAGE_ERASE_VIOLATION_FLAG         1
`define EV_FULL_ERASE_VIOLATION_FLAG       0
`define PAGE_INFO_BIT     7
`define PGCTL_ROW         2
`define PGCTL_PAGE        1
`define PGCTL_MASS        0
`define ROW_PROGRAM_GO_TIMEOUT   4864
`define BLOCK_SHIFT       15
`endif

// ---- hdl/flash_guard_pkg.sv ----
// Types shared by the flash protection block
package flash_guard_pkg;
  typedef enum logic [1:0] {
    key_locked,
    key_half,
    key_open
  } key_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ---- hdl/row_program_timer.sv ----
// Row program timeout counter in flash controller clocks
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
module row_program_timer #(
  parameter int LIMIT = `ROW_PROGRAM_GO_TIMEOUT
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic active_in,
  input  wire logic fclk_tick_in,
  output logic      expire_out
);
  // Counter is 13 bits wide; a limit past 8192 would wrap in the compare and expire early
  if (LIMIT < 2 || LIMIT > 8191) begin : g_bad_limit
    $error("row_program_timer: LIMIT out of range");
  end

  logic [12:0] count;
  logic [12:0] next_count;
  logic        next_expire;

  // Counts controller ticks while programming; restarts when idle
  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (!active_in) begin
      next_count = 13'h0000;
    end else if (fclk_tick_in) begin
      if (count == 13'(LIMIT - 1)) begin
        next_expire = 1'b1;
        next_count  = 13'h0000;
      end else begin
        next_count = count + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      count      <= 13'h0000;
      expire_out <= 1'b0;
    end else begin
      count      <= next_count;
      expire_out <= next_expire;
    end
  end
endmodule

// ---- hdl/flash_protect_irq_page_select.sv ----
// Flash protection mask, event/interrupt register and page select
//
// Summary of operation
// - Eight 32 KB blocks; a set mask bit blocks writes and erases there.
// - Mask bit n guards the range starting at n times 8000h.
// - Reset sets all eight mask bits, protecting every block.
// - Boot block protected when write-protect pin low or mask bit 0 set.
// - Mask writes need the key; a locked write forces the mask to FFh.
// - Info page has no mask bit; excluded from mass erase unless selected.
// - Completion flag sets when page erase, mass erase or row program ends well.
// - Row program not done in 4864 controller clocks is aborted and flagged.
// - Write to a protected block is dropped and write violation flagged.
// - Page erase of a protected block is dropped and flagged.
// - Mass erase with any block protected is dropped and flagged.
// - With write-protect asserted, boot page erase or mass erase fails, flagged.
// - Two interrupt sources, completion and error, each with its enable.
// - Error enable lets any of four error flags raise the interrupt.
// - Event layout: enables 7,6; done 5; reserved 4; errors 3 to 0.
// - Reading event register clears bits 5 and 3..0, keeps enables.
// - Page bit 7 selects info page for access/erase and includes it in mass erase.
// - Low seven bits pick one of 128 main pages; ignored for info page.
// - Each data register access increments the column; its carry steps row, then page.
// - Page and mass erase control bits self-clear on completion.
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
module flash_protect_irq_page_select #(
  parameter int ROW_TIMEOUT = `ROW_PROGRAM_GO_TIMEOUT
) (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  output logic [7:0]      io_rdata_out,
  input  wire logic       write_protect_n_in,
  input  wire logic       fclk_tick_in,
  input  wire logic       page_erase_done_in,
  input  wire logic       mass_erase_done_in,
  input  wire logic       row_program_done_in,
  input  wire logic       flash_write_req_in,
  input  wire logic [17:0] flash_write_addr_in,
  output logic            flash_write_grant_out,
  output logic            page_erase_go_out,
  output logic            mass_erase_go_out,
  output logic            row_program_go_out,
  output logic            mass_include_info_out,
  output logic            info_select_out,
  output logic [6:0]      page_out,
  output logic [2:0]      row_out,
  output logic [7:0]      col_out,
  output logic            irq_out
);
  if (ROW_TIMEOUT < 2 || ROW_TIMEOUT > 8191) begin : g_bad_timeout
    $error("ROW_TIMEOUT out of range");
  end

  // Block index of an 18-bit flash offset
  function automatic logic [2:0] block_of(input logic [17:0] a);
    block_of = a[17:`BLOCK_SHIFT];
  endfunction

  // Register select decode used by both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Write-protect pin from outside: three-stage synchroniser
  logic [2:0] wp_sync;
  logic       wp_asserted;
  logic       next_wp_asserted;
  always_comb begin
    next_wp_asserted = wp_asserted;
    if (wp_sync[1] == wp_sync[2]) next_wp_asserted = !wp_sync[2];
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wp_sync     <= 3'h7;
      wp_asserted <= 1'b0;
    end else begin
      wp_sync     <= {wp_sync[1:0], write_protect_n_in};
      wp_asserted <= next_wp_asserted;
    end
  end

  flash_guard_pkg::key_state_e key_state;
  flash_guard_pkg::key_state_e next_key_state;
  flash_guard_pkg::byte_t      protect;
  flash_guard_pkg::byte_t      next_protect;
  flash_guard_pkg::byte_t      event_reg;
  flash_guard_pkg::byte_t      next_event_reg;
  flash_guard_pkg::byte_t      page_sel;
  flash_guard_pkg::byte_t      next_page_sel;
  logic [2:0] row;
  logic [2:0] next_row;
  logic [7:0] col;
  logic [7:0] next_col;
  logic [2:0] pgctl;
  logic [2:0] next_pgctl;
  logic [7:0] next_rdata;
  logic       row_timeout;

  logic wr_key;
  logic wr_prot;
  logic wr_page;
  logic wr_row;
  logic wr_col;
  logic wr_pgctl;
  logic rd_event;
  logic data_acc;
  assign wr_key   = io_wr_in && hit(io_addr_in, `ADDR_KEY);
  assign wr_prot  = io_wr_in && hit(io_addr_in, `ADDR_PROTECT);
  assign wr_page  = io_wr_in && hit(io_addr_in, `ADDR_PAGE);
  assign wr_row   = io_wr_in && hit(io_addr_in, `ADDR_ROW);
  assign wr_col   = io_wr_in && hit(io_addr_in, `ADDR_COL);
  assign wr_pgctl = io_wr_in && hit(io_addr_in, `ADDR_PGCTL);
  assign rd_event = io_rd_in && hit(io_addr_in, `ADDR_EVENT);
  assign data_acc = (io_wr_in || io_rd_in) && hit(io_addr_in, `ADDR_DATA);

  // Effective protection per block; the pin adds to bit 0
  logic [7:0] eff_protect;
  assign eff_protect = {protect[7:1], protect[0] | wp_asserted};

  // Page erase target block; the info page carries no mask bit
  logic       page_blocked;
  assign page_blocked = !page_sel[`PAGE_INFO_BIT] &&
                        eff_protect[page_sel[6:4]];
  // Any set bit, or the pin, blocks a mass erase
  logic       mass_blocked;
  assign mass_blocked = |eff_protect;

  // Attempted starts from a control register write
  logic page_start;
  logic mass_start;
  assign page_start = wr_pgctl && io_wdata_in[`PGCTL_PAGE] && !pgctl[`PGCTL_PAGE];
  assign mass_start = wr_pgctl && io_wdata_in[`PGCTL_MASS] && !pgctl[`PGCTL_MASS];

  assign flash_write_grant_out = flash_write_req_in &&
                                 !eff_protect[block_of(flash_write_addr_in)];

  // Key sequencer; any other write to the key register relocks
  always_comb begin
    next_key_state = key_state;
    if (wr_key) begin
      unique case (key_state)
        flash_guard_pkg::key_locked:
          next_key_state = (io_wdata_in == `KEY_FIRST) ? flash_guard_pkg::key_half
                                                       : flash_guard_pkg::key_locked;
        flash_guard_pkg::key_half:
          next_key_state = (io_wdata_in == `KEY_SECOND) ? flash_guard_pkg::key_open
                                                        : flash_guard_pkg::key_locked;
        flash_guard_pkg::key_open:
          next_key_state = (io_wdata_in == `KEY_FIRST) ? flash_guard_pkg::key_half
                                                       : flash_guard_pkg::key_locked;
        default: next_key_state = flash_guard_pkg::key_locked; // Unused code relocks
      endcase
    end else if (wr_prot) begin
      next_key_state = flash_guard_pkg::key_locked; // Unlock covers one write only
    end
  end

  // Protection mask
  always_comb begin
    next_protect = protect;
    if (wr_prot) begin
      if (key_state == flash_guard_pkg::key_open) next_protect = io_wdata_in;
      else next_protect = `PROTECT_RESET;
    end
  end

  // Program control bits; erases self-clear on done, rejected starts never set
  always_comb begin
    next_pgctl = pgctl;
    if (page_start && !page_blocked) next_pgctl[`PGCTL_PAGE] = 1'b1;
    if (mass_start && !mass_blocked) next_pgctl[`PGCTL_MASS] = 1'b1;
    if (wr_pgctl) next_pgctl[`PGCTL_ROW] = io_wdata_in[`PGCTL_ROW];
    if (page_erase_done_in) next_pgctl[`PGCTL_PAGE] = 1'b0;
    if (mass_erase_done_in) next_pgctl[`PGCTL_MASS] = 1'b0;
    if (row_program_done_in || row_timeout) next_pgctl[`PGCTL_ROW] = 1'b0;
  end

  // Event register: clear on read first, then new events win
  always_comb begin
    next_event_reg = event_reg;
    if (io_wr_in && hit(io_addr_in, `ADDR_EVENT)) begin
      next_event_reg[`EV_COMPLETION_IRQ_ENABLE] = io_wdata_in[`EV_COMPLETION_IRQ_ENABLE];
      next_event_reg[`EV_ERROR_IRQ_ENABLE]  = io_wdata_in[`EV_ERROR_IRQ_ENABLE];
    end
    if (rd_event) begin
      next_event_reg[`EV_DONE]        = 1'b0;
      next_event_reg[`EV_WRITE_VIOLATION_FLAG:0]    = 4'h0;
    end
    next_event_reg[4] = 1'b0;
    if ((page_erase_done_in && pgctl[`PGCTL_PAGE]) ||
        (mass_erase_done_in && pgctl[`PGCTL_MASS]) ||
        (row_program_done_in && pgctl[`PGCTL_ROW]))
      next_event_reg[`EV_DONE] = 1'b1;
    if (flash_write_req_in && !flash_write_grant_out)
      next_event_reg[`EV_WRITE_VIOLATION_FLAG] = 1'b1;
    if (row_timeout) next_event_reg[`EV_ROW_PROGRAM_TIMEOUT_FLAG] = 1'b1;
    if (page_start && page_blocked) next_event_reg[`EV_PAGE_ERASE_VIOLATION_FLAG] = 1'b1;
    if (mass_start && mass_blocked) next_event_reg[`EV_FULL_ERASE_VIOLATION_FLAG] = 1'b1;
  end

  // Page, row and column address with autoincrement on data access
  always_comb begin
    next_page_sel = page_sel;
    next_row      = row;
    next_col      = col;
    if (wr_page) next_page_sel = io_wdata_in;
    if (wr_row) next_row = io_wdata_in[2:0];
    if (wr_col) next_col = io_wdata_in;
    if (data_acc) begin
      next_col = col + 8'h01;
      if (col == 8'hFF) begin
        next_row = row + 3'h1;
        if (row == 3'h7) next_page_sel[6:0] = page_sel[6:0] + 7'h01;
      end
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (io_rd_in) begin
      unique case (io_addr_in)
        `ADDR_PROTECT: next_rdata = protect;
        `ADDR_EVENT:   next_rdata = event_reg;
        `ADDR_PAGE:    next_rdata = page_sel;
        `ADDR_ROW:     next_rdata = {5'h00, row};
        `ADDR_COL:     next_rdata = col;
        `ADDR_PGCTL:   next_rdata = {5'h00, pgctl};
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // Key sequencer state; reset leaves the mask locked
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      key_state <= flash_guard_pkg::key_locked;
    end else begin
      key_state <= next_key_state;
    end
  end

  // Protection mask; reset guards every block
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      protect <= `PROTECT_RESET;
    end else begin
      protect <= next_protect;
    end
  end

  // Program control bits
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pgctl <= 3'h0;
    end else begin
      pgctl <= next_pgctl;
    end
  end

  // Event flags and interrupt enables
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      event_reg <= `EVENT_RESET;
    end else begin
      event_reg <= next_event_reg;
    end
  end

  // Page, row and column address registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      page_sel <= `PAGE_RESET;
      row      <= 3'h0;
      col      <= 8'h00;
    end else begin
      page_sel <= next_page_sel;
      row      <= next_row;
      col      <= next_col;
    end
  end

  // Read data; zero between reads so no stale value lingers on the bus
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      io_rdata_out <= 8'h00;
    end else begin
      io_rdata_out <= next_rdata;
    end
  end

  row_program_timer #(
    .LIMIT(ROW_TIMEOUT)
  ) u_row_timer (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .active_in   (pgctl[`PGCTL_ROW]),
    .fclk_tick_in(fclk_tick_in),
    .expire_out  (row_timeout)
  );

  // Outputs toward the erase/program sequencer and interrupt controller
  assign page_erase_go_out     = pgctl[`PGCTL_PAGE];
  assign mass_erase_go_out     = pgctl[`PGCTL_MASS];
  assign row_program_go_out    = pgctl[`PGCTL_ROW];
  assign mass_include_info_out = page_sel[`PAGE_INFO_BIT];
  assign info_select_out       = page_sel[`PAGE_INFO_BIT];
  assign page_out              = page_sel[`PAGE_INFO_BIT] ? 7'h00 : page_sel[6:0];
  assign row_out               = row;
  assign col_out               = col;
  assign irq_out = (event_reg[`EV_COMPLETION_IRQ_ENABLE] && event_reg[`EV_DONE]) ||
                   (event_reg[`EV_ERROR_IRQ_ENABLE] && |event_reg[`EV_WRITE_VIOLATION_FLAG:0]);
endmodule

// ---- verification/flash_array_model.sv ----
// Behavioural flash sequencer answering the go bits
`timescale 1ns/1ps
module flash_array_model #(
  parameter int DELAY = 6
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic stall_row_in,
  input  wire logic page_go_in,
  input  wire logic mass_go_in,
  input  wire logic row_go_in,
  output logic      fclk_tick_out,
  output logic      page_done_out,
  output logic      mass_done_out,
  output logic      row_done_out
);
  logic [1:0] div;
  int         busy;
  // Tick divider and age of the running operation
  always_ff @(posedge clk_sys_in) begin
    div  <= sys_rst_in ? 2'h0 : div + 2'h1;
    busy <= (sys_rst_in || !(page_go_in | mass_go_in | row_go_in)) ? 0 : busy + 1;
  end
  assign fclk_tick_out = div == 2'h3;
  // One-cycle success pulses; a stalled row never reports, so the timeout must act
  assign page_done_out = page_go_in && busy == DELAY;
  assign mass_done_out = mass_go_in && busy == DELAY;
  assign row_done_out  = row_go_in && !stall_row_in && busy == DELAY;
endmodule

// ---- verification/flash_guard_checker.sv ----
// Port assertions for the flash guard block
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
module flash_guard_checker #(
  parameter int ROW_TIMEOUT = 8
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  io_addr_in,
  input wire logic        io_wr_in,
  input wire logic [7:0]  io_wdata_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_rdata_out,
  input wire logic        write_protect_n_in,
  input wire logic        fclk_tick_in,
  input wire logic        page_erase_done_in,
  input wire logic        mass_erase_done_in,
  input wire logic        row_program_done_in,
  input wire logic        flash_write_req_in,
  input wire logic [17:0] flash_write_addr_in,
  input wire logic        flash_write_grant_out,
  input wire logic        page_erase_go_out,
  input wire logic        mass_erase_go_out,
  input wire logic        row_program_go_out,
  input wire logic        mass_include_info_out,
  input wire logic        info_select_out,
  input wire logic [6:0]  page_out,
  input wire logic        irq_out
);
  int unsigned ticks;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  // Ticks seen during one row program
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !row_program_go_out)
      ticks <= 0;
    else if (fclk_tick_in)
      ticks <= ticks + 1;
  end
  // Pin held low long enough to pass its synchroniser
  sequence wp_held;
    !write_protect_n_in [*5];
  endsequence
  sequence ev_read;
    io_rd_in && io_addr_in == `ADDR_EVENT;
  endsequence
  AST_IRQ_SRC: assert property (ev_read |=> $past(irq_out) ==
    (io_rdata_out[7] & io_rdata_out[5] | io_rdata_out[6] & (|io_rdata_out[3:0])))
    else $error("irq does not follow event bits");
  AST_READ_CLEARS: assert property (ev_read ##0 !(page_erase_done_in | mass_erase_done_in |
    row_program_done_in | flash_write_req_in | row_program_go_out) ##1 ev_read |=>
    io_rdata_out[5] == 1'h0 && io_rdata_out[3:0] == 4'h0 &&
    io_rdata_out[7:6] == $past(io_rdata_out[7:6])) else $error("read left flags set");
  AST_RSVD_ZERO: assert property (ev_read |=> io_rdata_out[4] == 1'h0)
    else $error("reserved event bit set");
  AST_ROW_LIMIT: assert property (row_program_go_out |-> ticks <= ROW_TIMEOUT)
    else $error("row program outlived its limit");
  AST_INFO_MASS: assert property (io_wr_in && io_addr_in == `ADDR_PAGE |=>
    info_select_out == $past(io_wdata_in[`PAGE_INFO_BIT]) &&
    mass_include_info_out == $past(io_wdata_in[`PAGE_INFO_BIT]))
    else $error("info page inclusion wrong");
  AST_INFO_PAGE: assert property (info_select_out |-> page_out == 7'h00)
    else $error("page bits not ignored for info page");
  AST_SELF_CLEAR: assert property ((page_erase_go_out && page_erase_done_in |=>
    !page_erase_go_out) and (mass_erase_go_out && mass_erase_done_in |=> !mass_erase_go_out))
    else $error("erase bit stuck");
  AST_WP_BOOT: assert property (wp_held ##0 flash_write_req_in &&
    flash_write_addr_in[17:15] == 3'h0 |-> !flash_write_grant_out) else $error("boot write");
  AST_GRANT_REQ: assert property (flash_write_grant_out |-> flash_write_req_in)
    else $error("grant without request");
endmodule

bind flash_protect_irq_page_select flash_guard_checker #(.ROW_TIMEOUT(ROW_TIMEOUT)) chk (.*);

// ---- verification/flash_protect_irq_page_select_tb_top.sv ----
// Self-checking bench for the flash guard block
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
module flash_protect_irq_page_select_tb_top;
  logic        clk_sys_in = 1'h0;
  logic        sys_rst_in = 1'h1;
  logic        io_wr_in = 1'h0;
  logic        io_rd_in = 1'h0;
  logic        write_protect_n_in = 1'h1;
  logic        flash_write_req_in = 1'h0;
  logic        stall_row = 1'h0;
  logic [7:0]  io_addr_in = 8'h00;
  logic [7:0]  io_wdata_in = 8'h00;
  logic [17:0] flash_write_addr_in = 18'h00000;
  logic [7:0]  io_rdata_out, col_out, rd;
  logic [6:0]  page_out;
  logic [2:0]  row_out;
  logic        fclk_tick_in, page_erase_done_in, mass_erase_done_in, row_program_done_in;
  logic        flash_write_grant_out, page_erase_go_out, mass_erase_go_out, row_program_go_out;
  logic        mass_include_info_out, info_select_out, irq_out;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;

  flash_protect_irq_page_select #(.ROW_TIMEOUT(8)) dut (.*);
  flash_array_model model (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .stall_row_in(stall_row), .page_go_in(page_erase_go_out), .mass_go_in(mass_erase_go_out),
    .row_go_in(row_program_go_out), .fclk_tick_out(fclk_tick_in),
    .page_done_out(page_erase_done_in), .mass_done_out(mass_erase_done_in),
    .row_done_out(row_program_done_in));

  always #25 clk_sys_in = ~clk_sys_in;
  // Hang guard, several times the planned run
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus tasks start after a rising edge and leave one idle cycle
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    io_addr_in  <= a;
    io_wdata_in <= d;
    io_wr_in    <= 1'h1;
    @(posedge clk_sys_in);
    io_wr_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  // Strobe held n edges gives n back-to-back reads; last answer kept
  task automatic io_read(input logic [7:0] a, input int n, output logic [7:0] d);
    io_addr_in <= a;
    io_rd_in   <= 1'h1;
    repeat (n) @(posedge clk_sys_in);
    io_rd_in <= 1'h0;
    @(negedge clk_sys_in);
    d = io_rdata_out;
    @(posedge clk_sys_in);
  endtask
  task automatic unlock_mask(input logic [7:0] m);
    io_write(`ADDR_KEY, `KEY_FIRST);
    io_write(`ADDR_KEY, `KEY_SECOND);
    io_write(`ADDR_PROTECT, m);
  endtask
  // Grant is combinational, so it is looked at mid-cycle
  task automatic try_write(input logic [17:0] a, input logic g);
    flash_write_addr_in <= a;
    flash_write_req_in  <= 1'h1;
    @(negedge clk_sys_in);
    check("grant", flash_write_grant_out, g);
    @(posedge clk_sys_in);
    flash_write_req_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  // Bounded wait for the sequencer, then go bits and interrupt
  task automatic settle(input logic [3:0] exp, input int n);
    for (int i = 0; i < n && (page_erase_go_out | mass_erase_go_out | row_program_go_out); i++)
      @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check("go_irq", {page_erase_go_out, mass_erase_go_out, row_program_go_out, irq_out}, exp);
    @(posedge clk_sys_in);
  endtask

  task automatic t_reset();
    io_read(`ADDR_PROTECT, 1, rd);
    check("mask", rd, `PROTECT_RESET);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, `EVENT_RESET);
    io_read(`ADDR_PAGE, 1, rd);
    check("page", rd, `PAGE_RESET);
    io_read(8'h10, 1, rd);
    check("unmapped", rd, 8'h00);
    try_write(18'h3FFFF, 1'h0);
  endtask
  // One guarded block at a time, edges of each range
  task automatic t_blocks();
    for (int n = 0; n < 8; n++) begin
      unlock_mask(8'h01 << n);
      try_write(18'(n * 32'h8000), 1'h0);
      try_write(18'(n * 32'h8000 + 32'h7FFF), 1'h0);
      try_write(18'(n * 32'h8000 + 32'h8000), 1'h1);
    end
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h08);
    io_write(`ADDR_PROTECT, 8'h00);
    io_read(`ADDR_PROTECT, 1, rd);
    check("mask", rd, 8'hFF);
  endtask
  // Refused write on the same edge as the clearing read
  task automatic t_coincide();
    flash_write_req_in <= 1'h1;
    io_addr_in         <= `ADDR_EVENT;
    io_rd_in           <= 1'h1;
    @(posedge clk_sys_in);
    flash_write_req_in <= 1'h0;
    io_rd_in           <= 1'h0;
    @(negedge clk_sys_in);
    check("event", io_rdata_out, 8'h00);
    @(posedge clk_sys_in);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h08);
  endtask
  task automatic t_boot();
    unlock_mask(8'h00);
    write_protect_n_in <= 1'h0;
    repeat (5) @(posedge clk_sys_in);
    try_write(18'h07FFF, 1'h0);
    try_write(18'h08000, 1'h1);
    io_write(`ADDR_PAGE, 8'h00);
    io_write(`ADDR_PGCTL, 8'h02);
    io_write(`ADDR_PGCTL, 8'h01);
    settle(4'h0, 0);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h0B);
    write_protect_n_in <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
  endtask
  task automatic t_events();
    io_write(`ADDR_EVENT, 8'hC0);
    io_write(`ADDR_PAGE, 8'h23);
    io_write(`ADDR_PGCTL, 8'h02);
    settle(4'h8, 0);
    settle(4'h1, 20);
    io_read(`ADDR_EVENT, 2, rd);
    check("event", rd, 8'hC0);
    io_write(`ADDR_PGCTL, 8'h01);
    settle(4'h1, 20);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'hE0);
    io_write(`ADDR_PROTECT, 8'h00);
    io_write(`ADDR_PGCTL, 8'h02);
    io_write(`ADDR_PGCTL, 8'h01);
    settle(4'h1, 0);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'hC3);
    io_write(`ADDR_EVENT, 8'h80);
    try_write(18'h10000, 1'h0);
    settle(4'h0, 0);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h88);
  endtask
  task automatic t_row();
    unlock_mask(8'h00);
    io_write(`ADDR_EVENT, 8'h00);
    stall_row <= 1'h1;
    io_write(`ADDR_PGCTL, 8'h04);
    io_read(`ADDR_PGCTL, 1, rd);
    check("pgctl", rd, 8'h04);
    settle(4'h2, 0);
    settle(4'h0, 100);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h04);
    stall_row <= 1'h0;
    io_write(`ADDR_PGCTL, 8'h04);
    settle(4'h0, 40);
    io_read(`ADDR_EVENT, 1, rd);
    check("event", rd, 8'h20);
  endtask
  task automatic t_addr();
    io_write(`ADDR_PAGE, 8'h7F);
    io_write(`ADDR_ROW, 8'h07);
    io_write(`ADDR_COL, 8'hFF);
    io_read(`ADDR_COL, 1, rd);
    check("col", rd, 8'hFF);
    io_read(`ADDR_DATA, 1, rd);
    check("address", {page_out, row_out, col_out}, 18'h00000);
    io_write(`ADDR_PAGE, 8'h85);
    @(negedge clk_sys_in);
    check("info", {info_select_out, mass_include_info_out, page_out}, 9'h180);
    @(posedge clk_sys_in);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'h0;
    t_reset();
    t_blocks();
    t_coincide();
    t_boot();
    t_events();
    t_row();
    t_addr();
    report_and_stop();
  end
endmodule
